// ===== rtl/brsq_sequencer.sv
// Brown-out, power-up delay and start-up timer reset sequencer with APB
`timescale 1ns/1ps
`default_nettype none

module brsq_sequencer
#(
  parameter int unsigned TIMEBASE_CYCLES = brsq_pkg::TIMEBASE_CYCLES
)
(
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Supply monitor, reset pin, crystal input and fuses
  input  wire brsq_pkg::brsq_pins_t pins,
  // Core events
  input  wire logic                 wdt_timeout,
  input  wire logic                 sleep_enter,
  input  wire logic                 irq_wake_pin,
  input  wire logic                 irq_wake_port,
  input  wire logic [3:0]           periph_wake,
  // Core control
  output logic                      core_reset,
  output logic                      core_stall,
  output logic                      pc_load,
  output logic                      pc_increment,
  output logic [12:0]               pc_value
);

  brsq_pkg::brsq_pins_t       sp;
  brsq_pkg::brsq_state_t      state;
  brsq_pkg::brsq_state_t      next_state;
  brsq_pkg::brsq_hold_cause_t hold_cause;
  logic [7:0]  cpu_flags_and_bank;
  logic [7:0]  reset_cause_register;
  logic [7:0]  interrupt_control_register;
  logic [7:0]  periph_flags;
  logic [7:0]  option_register;
  logic [5:0]  pin_direction;
  logic [brsq_pkg::TIMEBASE_CNT_W-1:0] tick_cnt;
  logic [brsq_pkg::DELAY_CNT_W-1:0]    delay_cnt;
  logic [brsq_pkg::BROWNOUT_CNT_W-1:0] brownout_cnt;
  logic [brsq_pkg::STARTUP_CNT_W-1:0]  startup_cnt;
  logic        por_seen;
  logic        external_reset_pin_low_prev;
  logic        osc1_prev;
  logic        wake_by_irq;
  logic        vector_pending;
  logic        next_core_reset;
  logic        external_reset_pin_low;
  logic        crystal;
  logic        delay_enabled;
  logic        tick;
  logic        delay_done;
  logic        osc_rise;
  logic        startup_done;
  logic        evt_por;
  logic        evt_bod;
  logic        evt_external_reset_pin;
  logic        evt_wdt_reset;
  logic        evt_wdt_wake;
  logic        evt_irq_wake;
  logic        evt_any_reset;
  logic        wake_done;
  logic [7:0]  periph_set;
  logic        apb_write;
  logic        apb_setup;
  logic [9:0]  reg_idx;
  logic        addr_hit;
  logic [7:0]  read_value;

  brsq_sync3 u_sync
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .pins_async (pins),
    .pins_sync  (sp)
  );

  assign external_reset_pin_low      = !sp.external_reset_pin_n;
  assign crystal       = (sp.osc_mode == brsq_pkg::OSC_LOW_POWER_CRYSTAL)
                      || (sp.osc_mode == brsq_pkg::OSC_CRYSTAL_MODE)
                      || (sp.osc_mode == brsq_pkg::OSC_HIGH_SPEED_CRYSTAL);
  assign delay_enabled = !sp.power_up_delay_disable;

  // Event decode
  assign evt_por       = sp.por_pulse && !por_seen;
  assign evt_bod       = sp.brownout_enable_fuse && sp.supply_below_trip
    && (brownout_cnt == brsq_pkg::BROWNOUT_CNT_W'(
          brsq_pkg::BROWNOUT_MIN_CYCLES - 1));
  assign evt_external_reset_pin      = external_reset_pin_low && !external_reset_pin_low_prev;
  assign evt_wdt_reset = wdt_timeout && (state == brsq_pkg::SEQ_RUN);
  assign evt_wdt_wake  = wdt_timeout && (state == brsq_pkg::SEQ_SLEEP);
  assign evt_irq_wake  = (irq_wake_pin || irq_wake_port
                         || (periph_wake != 4'h0))
                         && (state == brsq_pkg::SEQ_SLEEP) && !wdt_timeout;
  assign evt_any_reset = evt_por || evt_bod || evt_external_reset_pin || evt_wdt_reset;
  assign periph_set    = {periph_wake[3], periph_wake[2], 2'b00,
                          periph_wake[1], 2'b00, periph_wake[0]};

  // Separate timebase for the power-up delay
  assign tick       = (tick_cnt == brsq_pkg::TIMEBASE_CNT_W'(
                        TIMEBASE_CYCLES - 1));
  assign delay_done = tick && (delay_cnt == brsq_pkg::DELAY_CNT_W'(
                        brsq_pkg::POWER_UP_DELAY_MS - 1));
  // Crystal input must run at or below a quarter of pclk to be counted
  assign osc_rise     = sp.osc1_clock && !osc1_prev;
  assign startup_done = osc_rise && (startup_cnt == brsq_pkg::STARTUP_CNT_W'(
                          brsq_pkg::CRYSTAL_STARTUP_PERIODS - 1));
  assign wake_done    = ((state == brsq_pkg::SEQ_WAKE_STARTUP)
                         && startup_done)
                     || ((state == brsq_pkg::SEQ_SLEEP)
                         && (evt_wdt_wake || evt_irq_wake) && !crystal
                         && !evt_external_reset_pin);

  always_comb
  begin
    next_state = state;
    unique case (state)
      brsq_pkg::SEQ_HOLD:
        if (!sp.por_pulse && sp.supply_above_release)
        begin
          if (delay_enabled)
            next_state = brsq_pkg::SEQ_DELAY;
          else if (crystal && hold_cause != brsq_pkg::HOLD_OTHER)
            next_state = brsq_pkg::SEQ_STARTUP;
          else
            next_state = brsq_pkg::SEQ_RUN;
        end
      brsq_pkg::SEQ_DELAY:
        if (!sp.supply_above_release)
          next_state = brsq_pkg::SEQ_HOLD;
        else if (delay_done)
          next_state = crystal ? brsq_pkg::SEQ_STARTUP
                               : brsq_pkg::SEQ_RUN;
      brsq_pkg::SEQ_STARTUP:
        if (startup_done)
          next_state = brsq_pkg::SEQ_RUN;
      brsq_pkg::SEQ_RUN:
        if (sleep_enter && !evt_wdt_reset && !external_reset_pin_low)
          next_state = brsq_pkg::SEQ_SLEEP;
      brsq_pkg::SEQ_SLEEP:
        if (evt_external_reset_pin)
          next_state = brsq_pkg::SEQ_RUN;
        else if (evt_wdt_wake || evt_irq_wake)
          next_state = crystal ? brsq_pkg::SEQ_WAKE_STARTUP
                               : brsq_pkg::SEQ_RUN;
      brsq_pkg::SEQ_WAKE_STARTUP:
        if (startup_done)
          next_state = brsq_pkg::SEQ_RUN;
      default:
        next_state = brsq_pkg::SEQ_HOLD;
    endcase
    if (sp.por_pulse || evt_bod)
      next_state = brsq_pkg::SEQ_HOLD;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= brsq_pkg::SEQ_HOLD;
      hold_cause <= brsq_pkg::HOLD_POWER_ON;
    end
    else
    begin
      state <= next_state;
      if (sp.por_pulse)
        hold_cause <= brsq_pkg::HOLD_POWER_ON;
      else if (evt_bod)
        hold_cause <= brsq_pkg::HOLD_BROWNOUT;
    end
  end

  // Edge history of pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_seen      <= 1'b1;
      external_reset_pin_low_prev <= 1'b0;
      osc1_prev     <= 1'b0;
    end
    else
    begin
      por_seen      <= sp.por_pulse;
      external_reset_pin_low_prev <= external_reset_pin_low;
      osc1_prev     <= sp.osc1_clock;
    end
  end

  // Brown-out duration filter saturates so one dip trips once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brownout_cnt <= '0;
    else if (!sp.brownout_enable_fuse || !sp.supply_below_trip)
      brownout_cnt <= '0;
    else if (brownout_cnt != brsq_pkg::BROWNOUT_CNT_W'(
               brsq_pkg::BROWNOUT_MIN_CYCLES))
      brownout_cnt <= brownout_cnt + 1'b1;
  end

  // Power-up delay restarts whenever the state is left
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt  <= '0;
      delay_cnt <= '0;
    end
    else if (state != brsq_pkg::SEQ_DELAY
             || next_state != brsq_pkg::SEQ_DELAY)
    begin
      tick_cnt  <= '0;
      delay_cnt <= '0;
    end
    else if (tick)
    begin
      tick_cnt  <= '0;
      delay_cnt <= delay_cnt + 1'b1;
    end
    else
      tick_cnt <= tick_cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      startup_cnt <= '0;
    else if (state != brsq_pkg::SEQ_STARTUP
             && state != brsq_pkg::SEQ_WAKE_STARTUP)
      startup_cnt <= '0;
    else if (osc_rise)
      startup_cnt <= startup_cnt + 1'b1;
  end

  // Core reset ignores the pin for timing, so release is immediate
  assign next_core_reset = (next_state == brsq_pkg::SEQ_HOLD)
                        || (next_state == brsq_pkg::SEQ_DELAY)
                        || (next_state == brsq_pkg::SEQ_STARTUP)
                        || external_reset_pin_low || evt_wdt_reset;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_reset <= 1'b1;
      core_stall <= 1'b0;
    end
    else
    begin
      core_reset <= next_core_reset;
      core_stall <= (next_state == brsq_pkg::SEQ_WAKE_STARTUP);
    end
  end

  // Program counter steering
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_load        <= 1'b0;
      pc_increment   <= 1'b0;
      pc_value       <= brsq_pkg::RESET_VECTOR;
      wake_by_irq    <= 1'b0;
      vector_pending <= 1'b0;
    end
    else
    begin
      pc_load      <= 1'b0;
      pc_increment <= wake_done;
      if (evt_wdt_wake || evt_irq_wake)
        wake_by_irq <= evt_irq_wake;
      // Watchdog wake never vectors, even after an earlier interrupt wake
      vector_pending <= wake_done
        && interrupt_control_register[brsq_pkg::IRQ_GIE_BIT]
        && (evt_irq_wake || (!evt_wdt_wake && wake_by_irq));
      if (core_reset && !next_core_reset)
      begin
        pc_load  <= 1'b1;
        pc_value <= brsq_pkg::RESET_VECTOR;
      end
      else if (vector_pending)
      begin
        pc_load  <= 1'b1;
        pc_value <= brsq_pkg::IRQ_VECTOR;
      end
    end
  end

  // APB decode; zero wait states
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && addr_hit;
  assign reg_idx   = paddr[11:2];
  assign pready    = 1'b1;

  always_comb
  begin
    addr_hit   = (paddr[1:0] == 2'b00);
    read_value = 8'h00;
    unique case (reg_idx)
      brsq_pkg::CPU_FLAGS_IDX:    read_value = cpu_flags_and_bank;
      brsq_pkg::RESET_CAUSE_IDX:  read_value = reset_cause_register;
      brsq_pkg::IRQ_CONTROL_IDX:  read_value = interrupt_control_register;
      brsq_pkg::PERIPH_FLAGS_IDX: read_value = periph_flags;
      brsq_pkg::OPTION_IDX:       read_value = option_register;
      brsq_pkg::PIN_DIR_IDX:      read_value = {2'b00, pin_direction};
      brsq_pkg::SEQ_STATUS_IDX:
        read_value = {sp.brownout_enable_fuse, delay_enabled, crystal,
                      core_stall, core_reset, state};
      default:                    addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata  <= {24'h00_0000, pwrite ? 8'h00 : read_value};
      pslverr <= !addr_hit;
    end
  end

  // Flags register; hardware events win over a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cpu_flags_and_bank <= brsq_pkg::CPU_FLAGS_POR;
    else if (evt_any_reset || evt_wdt_wake || evt_irq_wake || sleep_enter)
    begin
      if (evt_any_reset)
        cpu_flags_and_bank <= cpu_flags_and_bank
                            & brsq_pkg::CPU_FLAGS_KEEP;
      if (evt_por || evt_bod)
      begin
        cpu_flags_and_bank[brsq_pkg::FLAG_WDT_BIT]   <= 1'b1;
        cpu_flags_and_bank[brsq_pkg::FLAG_SLEEP_BIT] <= 1'b1;
      end
      else if (evt_external_reset_pin && state == brsq_pkg::SEQ_SLEEP)
      begin
        cpu_flags_and_bank[brsq_pkg::FLAG_WDT_BIT]   <= 1'b1;
        cpu_flags_and_bank[brsq_pkg::FLAG_SLEEP_BIT] <= 1'b0;
      end
      else if (evt_wdt_reset || evt_wdt_wake)
      begin
        cpu_flags_and_bank[brsq_pkg::FLAG_WDT_BIT] <= 1'b0;
        if (evt_wdt_wake)
          cpu_flags_and_bank[brsq_pkg::FLAG_SLEEP_BIT] <= 1'b0;
      end
      else if (evt_irq_wake || (sleep_enter && !evt_external_reset_pin))
      begin
        cpu_flags_and_bank[brsq_pkg::FLAG_WDT_BIT]   <= 1'b1;
        cpu_flags_and_bank[brsq_pkg::FLAG_SLEEP_BIT] <= 1'b0;
      end
    end
    else if (apb_write && reg_idx == brsq_pkg::CPU_FLAGS_IDX)
      cpu_flags_and_bank <= (pwdata[7:0] & brsq_pkg::CPU_FLAGS_SW_MASK)
                  | (cpu_flags_and_bank & ~brsq_pkg::CPU_FLAGS_SW_MASK);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_cause_register <= brsq_pkg::RESET_CAUSE_POR;
    else if (evt_por)
      reset_cause_register <= brsq_pkg::RESET_CAUSE_POR;
    else if (evt_bod)
    begin
      reset_cause_register[brsq_pkg::CAUSE_POR_BIT] <= 1'b1;
      reset_cause_register[brsq_pkg::CAUSE_BOD_BIT] <= 1'b0;
    end
    else if (apb_write && reg_idx == brsq_pkg::RESET_CAUSE_IDX)
      reset_cause_register <= pwdata[7:0] & brsq_pkg::RESET_CAUSE_SW_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_control_register <= brsq_pkg::IRQ_CONTROL_RESET;
    else if (evt_por)
      interrupt_control_register <= brsq_pkg::IRQ_CONTROL_RESET;
    else if (evt_any_reset)
      interrupt_control_register <= {7'h00,
        interrupt_control_register[brsq_pkg::IRQ_PORT_FLAG_BIT]};
    else if (evt_irq_wake)
    begin
      if (irq_wake_pin)
        interrupt_control_register[brsq_pkg::IRQ_PIN_FLAG_BIT] <= 1'b1;
      if (irq_wake_port)
        interrupt_control_register[brsq_pkg::IRQ_PORT_FLAG_BIT] <= 1'b1;
    end
    else if (apb_write && reg_idx == brsq_pkg::IRQ_CONTROL_IDX)
      interrupt_control_register <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      periph_flags <= brsq_pkg::PERIPH_FLAGS_RESET;
    else if (evt_any_reset)
      periph_flags <= brsq_pkg::PERIPH_FLAGS_RESET;
    else if (evt_irq_wake)
      periph_flags <= periph_flags | periph_set;
    else if (apb_write && reg_idx == brsq_pkg::PERIPH_FLAGS_IDX)
      periph_flags <= pwdata[7:0] & brsq_pkg::PERIPH_FLAGS_MASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      option_register <= brsq_pkg::OPTION_RESET;
      pin_direction   <= brsq_pkg::PIN_DIR_RESET;
    end
    else if (evt_any_reset)
    begin
      option_register <= brsq_pkg::OPTION_RESET;
      pin_direction   <= brsq_pkg::PIN_DIR_RESET;
    end
    else if (apb_write && reg_idx == brsq_pkg::OPTION_IDX)
      option_register <= pwdata[7:0];
    else if (apb_write && reg_idx == brsq_pkg::PIN_DIR_IDX)
      pin_direction <= pwdata[5:0];
  end

endmodule

`default_nettype wire

// ===== rtl/brsq_pkg.sv
// Package: constants, register map and types of the reset sequencer
`default_nettype none

package brsq_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS        = 100;
  localparam int unsigned POWER_UP_DELAY_MS    = 72;
  localparam int unsigned TIMEBASE_TICK_NS     = 1000000;
  localparam int unsigned TIMEBASE_CYCLES      =
    (TIMEBASE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BROWNOUT_MIN_DURATION_NS = 100000;
  localparam int unsigned BROWNOUT_MIN_CYCLES  =
    (BROWNOUT_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CRYSTAL_STARTUP_PERIODS = 1024;

  // Counter widths
  localparam int unsigned TIMEBASE_CNT_W = 24;
  localparam int unsigned DELAY_CNT_W    = 7;
  localparam int unsigned BROWNOUT_CNT_W = 11;
  localparam int unsigned STARTUP_CNT_W  = 11;

  // Register indices; byte address is four times the index
  localparam logic [9:0] CPU_FLAGS_IDX    = 10'h003;
  localparam logic [9:0] RESET_CAUSE_IDX  = 10'h08E;
  localparam logic [9:0] IRQ_CONTROL_IDX  = 10'h00B;
  localparam logic [9:0] PERIPH_FLAGS_IDX = 10'h00C;
  localparam logic [9:0] OPTION_IDX       = 10'h081;
  localparam logic [9:0] PIN_DIR_IDX      = 10'h085;
  localparam logic [9:0] SEQ_STATUS_IDX   = 10'h0F0;

  // Field positions
  localparam int unsigned FLAG_WDT_BIT        = 4;
  localparam int unsigned FLAG_SLEEP_BIT      = 3;
  localparam int unsigned CAUSE_POR_BIT       = 1;
  localparam int unsigned CAUSE_BOD_BIT       = 0;
  localparam int unsigned IRQ_GIE_BIT         = 7;
  localparam int unsigned IRQ_PIN_FLAG_BIT    = 1;
  localparam int unsigned IRQ_PORT_FLAG_BIT   = 0;

  // Reset values and masks
  localparam logic [7:0] CPU_FLAGS_POR       = 8'h18;
  localparam logic [7:0] CPU_FLAGS_KEEP      = 8'h1F;
  localparam logic [7:0] CPU_FLAGS_SW_MASK   = 8'hE7;
  localparam logic [7:0] RESET_CAUSE_POR     = 8'h00;
  localparam logic [7:0] RESET_CAUSE_SW_MASK = 8'h03;
  localparam logic [7:0] IRQ_CONTROL_RESET   = 8'h00;
  localparam logic [7:0] PERIPH_FLAGS_RESET  = 8'h00;
  localparam logic [7:0] PERIPH_FLAGS_MASK   = 8'hC9;
  localparam logic [7:0] OPTION_RESET        = 8'hFF;
  localparam logic [5:0] PIN_DIR_RESET       = 6'h3F;
  localparam logic [12:0] RESET_VECTOR       = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR         = 13'h0004;

  typedef enum logic [2:0] {
    OSC_LOW_POWER_CRYSTAL  = 3'b000,
    OSC_CRYSTAL_MODE       = 3'b001,
    OSC_HIGH_SPEED_CRYSTAL = 3'b010,
    OSC_EXTERNAL_CLOCK     = 3'b011,
    OSC_INTERNAL_IO        = 3'b100,
    OSC_INTERNAL_CLKOUT    = 3'b101,
    OSC_RC_IO              = 3'b110,
    OSC_RC_CLKOUT          = 3'b111
  } brsq_osc_mode_t;

  typedef enum logic [2:0] {
    SEQ_HOLD         = 3'b000,
    SEQ_DELAY        = 3'b001,
    SEQ_STARTUP      = 3'b010,
    SEQ_RUN          = 3'b011,
    SEQ_SLEEP        = 3'b100,
    SEQ_WAKE_STARTUP = 3'b101
  } brsq_state_t;

  typedef enum logic [1:0] {
    HOLD_POWER_ON = 2'b00,
    HOLD_BROWNOUT = 2'b01,
    HOLD_OTHER    = 2'b10
  } brsq_hold_cause_t;

  // Pins and fuses from outside the clock domain
  typedef struct packed {
    logic           por_pulse;
    logic           supply_below_trip;
    logic           supply_above_release;
    logic           external_reset_pin_n;
    logic           osc1_clock;
    logic           brownout_enable_fuse;
    logic           power_up_delay_disable;
    brsq_osc_mode_t osc_mode;
  } brsq_pins_t;

  localparam brsq_pins_t PINS_RESET = '{
    por_pulse:              1'b1,
    supply_below_trip:      1'b0,
    supply_above_release:   1'b0,
    external_reset_pin_n:   1'b1,
    osc1_clock:             1'b0,
    brownout_enable_fuse:   1'b0,
    power_up_delay_disable: 1'b0,
    osc_mode:               OSC_INTERNAL_IO
  };

endpackage

`default_nettype wire

// ===== rtl/brsq_sync3.sv
// Three-stage input synchroniser with agreement filter for pins and fuses
`timescale 1ns/1ps
`default_nettype none

module brsq_sync3
(
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Pins
  input  wire brsq_pkg::brsq_pins_t pins_async,
  output brsq_pkg::brsq_pins_t      pins_sync
);

  localparam int unsigned W = $bits(brsq_pkg::brsq_pins_t);
  localparam logic [W-1:0] RST = brsq_pkg::PINS_RESET;

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] filtered;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          stage1[i]   <= RST[i];
          stage2[i]   <= RST[i];
          stage3[i]   <= RST[i];
          filtered[i] <= RST[i];
        end
        else
        begin
          stage1[i] <= pins_async[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          // Change accepted only once two late stages agree
          if (stage2[i] == stage3[i])
            filtered[i] <= stage3[i];
        end
      end
    end
  endgenerate

  assign pins_sync = brsq_pkg::brsq_pins_t'(filtered);

endmodule

`default_nettype wire

// ===== dv/brsq_partner.sv
// Supply monitor, reset pin and crystal model feeding the pins
`timescale 1ns/1ps
`default_nettype none
module brsq_partner
(
  // Clock and requested levels
  input  wire logic                 pclk,
  input  wire brsq_pkg::brsq_pins_t want,
  input  wire logic                 osc_en,
  // Pins to the sequencer
  output var brsq_pkg::brsq_pins_t  pins
);
  logic [2:0] div = 3'h0;
  // Crystal stands low when stopped; eight cycles keeps it under pclk/6
  always @(posedge pclk) div <= osc_en ? div + 3'h1 : 3'h0;
  always_comb
  begin
    pins = want;
    pins.osc1_clock = div[2];
    pins.power_up_delay_disable =
      want.power_up_delay_disable & ~want.brownout_enable_fuse;
  end
endmodule
`default_nettype wire

// ===== dv/brsq_checker.sv
// Port assertions of the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module brsq_checker
#(
  parameter int unsigned TIMEBASE_CYCLES = 10
)
(
  // Clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // Watched ports
  input wire brsq_pkg::brsq_pins_t pins,
  input wire logic                 core_reset,
  input wire logic                 core_stall,
  input wire logic                 pc_load,
  input wire logic                 pc_increment,
  input wire logic [12:0]          pc_value
);
  localparam int DLY = brsq_pkg::POWER_UP_DELAY_MS * TIMEBASE_CYCLES;
  // Margin covers the pin synchroniser and the reset register
  localparam logic [10:0] BO_LATE = 11'(brsq_pkg::BROWNOUT_MIN_CYCLES + 12);
  logic [10:0] bo_cnt;
  logic [15:0] up_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) bo_cnt <= '0;
    else if (!(pins.brownout_enable_fuse && pins.supply_below_trip))
      bo_cnt <= '0;
    else if (bo_cnt != 11'h7FF) bo_cnt <= bo_cnt + 11'h1;
  // Counts only while nothing should restart the delay
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) up_cnt <= '0;
    else if (pins.por_pulse || !pins.supply_above_release ||
             pins.power_up_delay_disable || bo_cnt != '0) up_cnt <= '0;
    else if (up_cnt != 16'hFFFF) up_cnt <= up_cnt + 16'h1;
  sequence s_stall_end;
    $fell(core_stall);
  endsequence
  a_reset_vector: assert property ($fell(core_reset) |-> pc_load &&
    pc_value == brsq_pkg::RESET_VECTOR) else $error("no reset vector");
  a_irq_vector: assert property (pc_load && $past(pc_increment) |->
    pc_value == brsq_pkg::IRQ_VECTOR) else $error("bad irq vector");
  a_wake_running: assert property (pc_increment |-> !core_reset)
    else $error("resume while held");
  a_stall_resume: assert property (s_stall_end |-> ##[0:2] pc_increment)
    else $error("no resume after stall");
  a_pin_hold: assert property (!pins.external_reset_pin_n[*8]
    |-> core_reset) else $error("pin reset ignored");
  a_por_hold: assert property (pins.por_pulse[*8] |-> core_reset)
    else $error("power-on pulse ignored");
  a_release_hold: assert property (!pins.supply_above_release[*8]
    |-> core_reset) else $error("low supply ignored");
  a_brownout_trip: assert property (bo_cnt == BO_LATE |-> core_reset)
    else $error("brown-out ignored");
  a_delay_hold: assert property (up_cnt != 0 && up_cnt < DLY
    |-> core_reset) else $error("delay cut short");
endmodule
bind brsq_sequencer brsq_checker #(.TIMEBASE_CYCLES(TIMEBASE_CYCLES)) chk_i
(
  .pclk(pclk), .presetn(presetn), .pins(pins), .core_reset(core_reset),
  .core_stall(core_stall), .pc_load(pc_load), .pc_increment(pc_increment),
  .pc_value(pc_value)
);
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench of the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                 pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic                 penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic                 osc_en = 1'b0, core_reset, core_stall;
  // Events: watchdog, sleep, pin, port, then peripheral wake 3:0 on 7:4
  logic [7:0]           ev = 8'h00;
  logic                 pc_load, pc_inc;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0, prdata, rd;
  logic [12:0]          pc_value;
  brsq_pkg::brsq_pins_t want = brsq_pkg::PINS_RESET, pins;
  int                   mismatches = 0, tests_run = 0, cyc = 0, n;
  brsq_partner far (.pclk(pclk), .want(want), .osc_en(osc_en), .pins(pins));
  brsq_sequencer #(.TIMEBASE_CYCLES(10)) dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .wdt_timeout(ev[0]),
    .sleep_enter(ev[1]), .irq_wake_pin(ev[2]), .irq_wake_port(ev[3]),
    .periph_wake(ev[7:4]), .core_reset(core_reset),
    .core_stall(core_stall), .pc_load(pc_load), .pc_increment(pc_inc),
    .pc_value(pc_value)
  );
  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    // Whole run needs about 13000 cycles
    if (cyc == 60000)
    begin
      mismatches++;
      test_done;
    end
  end
  task test_done;
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = pslverr ? 32'hEEEEEEEE : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rel(output int k);
    k = 0;
    while (core_reset !== 1'b0)
    begin
      @(posedge pclk);
      k++;
    end
  endtask
  task pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
  endtask
  task wake(input int s, input logic ld, output int k);
    pulse(1);
    repeat (8) @(posedge pclk);
    pulse(s);
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pc_inc !== 1'b1 && k < 9000);
    @(posedge pclk);
    chk(pc_load, ld);
  endtask
  task t_power_on;
    logic [11:0] a[7] = '{12'h00C, 12'h238, 12'h02C, 12'h030, 12'h204,
                          12'h214, 12'h100};
    logic [7:0]  v[7] = '{8'h18, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h3F, 8'hEE};
    want.osc_mode <= brsq_pkg::OSC_EXTERNAL_CLOCK;
    want.por_pulse <= 1'b0;
    want.supply_above_release <= 1'b1;
    rel(n);
    chk(n >= 720 && n <= 732, 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, a[i], 32'h0);
      chk(rd[7:0], v[i]);
    end
  endtask
  task t_pin;
    want.por_pulse <= 1'b1;
    want.external_reset_pin_n <= 1'b0;
    repeat (10) @(posedge pclk);
    want.por_pulse <= 1'b0;
    repeat (800) @(posedge pclk);
    chk(core_reset, 1'b1);
    want.external_reset_pin_n <= 1'b1;
    rel(n);
    chk(n <= 8, 1'b1);
  endtask
  task t_wake;
    pulse(0);
    repeat (4) @(posedge pclk);
    rel(n);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd[4:3], 2'b01);
    wake(0, 1'b0, n);
    chk(n <= 8, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd[4:3], 2'b00);
    apb(1'b1, 12'h02C, 32'h80);
    wake(2, 1'b1, n);
    chk(pc_value, 13'h0004);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd[4:3], 2'b10);
    apb(1'b1, 12'h02C, 32'h00);
    wake(7, 1'b0, n);
    wake(4, 1'b0, n);
    apb(1'b0, 12'h030, 32'h0);
    chk(rd[7:0], 8'h81);
  endtask
  task t_crystal;
    want.osc_mode <= brsq_pkg::OSC_CRYSTAL_MODE;
    osc_en <= 1'b1;
    wake(3, 1'b0, n);
    chk(n >= 8180 && n <= 8260, 1'b1);
    osc_en <= 1'b0;
    want.osc_mode <= brsq_pkg::OSC_EXTERNAL_CLOCK;
  endtask
  task t_brownout;
    apb(1'b1, 12'h238, 32'h03);
    want.supply_below_trip <= 1'b1;
    repeat (1100) @(posedge pclk);
    chk(core_reset, 1'b0);
    want.brownout_enable_fuse <= 1'b1;
    repeat (1100) @(posedge pclk);
    chk(core_reset, 1'b1);
    want.supply_below_trip <= 1'b0;
    repeat (300) @(posedge pclk);
    want.supply_above_release <= 1'b0;
    repeat (10) @(posedge pclk);
    want.supply_above_release <= 1'b1;
    rel(n);
    chk(n >= 720, 1'b1);
    apb(1'b0, 12'h238, 32'h0);
    chk(rd[1:0], 2'b10);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd[4:3], 2'b11);
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_power_on;
    t_pin;
    t_wake;
    t_crystal;
    t_brownout;
    test_done;
  end
endmodule
`default_nettype wire
